// ===== design/r4cs_defines.svh
`ifndef R4CS_DEFINES_SVH
`define R4CS_DEFINES_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define R4CS_IDX_CTRL     8'hd1
`define R4CS_IDX_SEQ      8'hd2
`define R4CS_IDX_LP       8'hd3
`define R4CS_IDX_STAT     8'hd4

// ==========================================================================
// Field positions.
`define R4CS_SWI_BIT      14
`define R4CS_OPFLT_BIT    10
`define R4CS_VSEL_LSB     0
`define R4CS_ACT_LSB      14
`define R4CS_ENS_LSB      10
`define R4CS_SDS_LSB      6
`define R4CS_HMODE_LSB    12
`define R4CS_HSRC_LSB     8
`define R4CS_VIMG_LSB     0
`define R4CS_HIB_BIT      0

// ==========================================================================
// Reset values.
`define R4CS_SWI_RST      1'b0
`define R4CS_OPFLT_RST    1'b0
`define R4CS_VSEL_RST     5'h1b
`define R4CS_ACT_RST      2'h0
`define R4CS_ENS_RST      4'h0
`define R4CS_SDS_RST      4'h0
`define R4CS_HMODE_RST    2'h0
`define R4CS_HSRC_RST     2'h0
`define R4CS_VIMG_RST     5'h1c

// ==========================================================================
// Codes.
`define R4CS_SLOT_NONE    4'h0
`define R4CS_SLOT_EDGE    4'hf
`define R4CS_ACT_IGNORE   2'h0
`define R4CS_ACT_REG      2'h1
`define R4CS_HMODE_IMAGE  2'h0
`define R4CS_HMODE_OFF    2'h1
`define R4CS_HSRC_BIT     2'h0

// ==========================================================================
// Voltage decode in millivolts.
`define R4CS_MV_LO_BASE   12'h384
`define R4CS_MV_LO_STEP   12'h032
`define R4CS_MV_HI_BASE   12'h708
`define R4CS_MV_HI_STEP   12'h064

`endif

// ===== design/r4cs_pkg.sv
package r4cs_pkg;

  typedef logic [4:0]  r4cs_code_t;
  typedef logic [11:0] r4cs_mv_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic             swi;
    logic             opflt;
    r4cs_code_t       vsel;
    logic [1:0]       act;
    logic [3:0]       ens;
    logic [3:0]       sds;
    logic [1:0]       hmode;
    logic [1:0]       hsrc;
    r4cs_code_t       vimg;
    logic             hib_bit;
    logic             en;
    logic [2:0]       fsync;
    logic             flt;
    logic [2:0][2:0]  lsync;
    logic [2:0]       lp;
    logic             o_en;
    logic             o_sw;
    logic             o_dis;
    logic             o_hib;
    r4cs_code_t       o_code;
    logic             irq;
    logic             sysdn;
  } r4cs_state_t;

endpackage

// ===== design/r4cs_vdec_if.sv
`timescale 1ns/1ps
interface r4cs_vdec_if;
  import r4cs_pkg::*;
  r4cs_code_t code;
  r4cs_mv_t   mv;
  modport ctl (output code, input mv);
  modport dec (input code, output mv);
endinterface

// ===== design/r4cs_vdecode.sv
`timescale 1ns/1ps
`include "r4cs_defines.svh"
module r4cs_vdecode (
  input wire logic  clock,   // 100 MHz clock
  input wire logic  sys_rst, // synchronous reset, active high
  r4cs_vdec_if.dec  vif      // code in, millivolts out
);
  import r4cs_pkg::*;

  r4cs_mv_t mv_q;
  r4cs_mv_t mv_d;

  // ========================================================================
  // Decode
  // two-range decode
  always_comb begin
    if (vif.code[4]) begin
      mv_d = `R4CS_MV_HI_BASE + `R4CS_MV_HI_STEP * {8'h00, vif.code[3:0]};
    end else begin
      mv_d = `R4CS_MV_LO_BASE + `R4CS_MV_LO_STEP * {8'h00, vif.code[3:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mv_q <= 12'h000;
    end else begin
      mv_q <= mv_d;
    end
  end

  assign vif.mv = mv_q;

  // ========================================================================
  // Checks
  // The first edge after reset still holds the cleared value, so it is skipped.
  vdec_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> (mv_q == ($past(vif.code[4]) ?
      12'h708 + 12'h064 * {8'h00, $past(vif.code[3:0])} :
      12'h384 + 12'h032 * {8'h00, $past(vif.code[3:0])})))
    else $error("voltage decode mismatch");
endmodule

// ===== design/r4cs_regulator.sv
`timescale 1ns/1ps
`include "r4cs_defines.svh"
module r4cs_regulator #(
  parameter logic [4:0] VSEL_DEFAULT = `R4CS_VSEL_RST, // mask option for the voltage code
  parameter logic [3:0] ENS_DEFAULT  = `R4CS_ENS_RST   // mask option for the start-up slot
) (
  input  wire logic              clock,               // 100 MHz clock
  input  wire logic              sys_rst,             // state machine reset, synchronous
  input  wire logic [9:0]        avs_address,         // byte address
  input  wire logic              avs_read,            // read request
  input  wire logic              avs_write,           // write request
  input  wire logic [31:0]       avs_writedata,       // write data
  output      logic [31:0]       avs_readdata,        // read data
  output      logic              avs_waitrequest,     // stall
  input  wire logic              slot_strobe,         // one pulse per sequencer slot
  input  wire logic [3:0]        slot_index,          // current slot number
  input  wire logic              seq_powering_up,     // 1 start-up walk, 0 shutdown walk
  input  wire logic              enter_active,        // pulse on entry to ACTIVE
  input  wire logic              enter_off,           // pulse on entry to OFF
  input  wire logic              fault_pin,           // regulator fault from analogue
  input  wire logic [2:0]        low_power_in,        // low-power inputs 3..1
  input  wire logic [2:0]        other_regs_off,      // the three other regulators off
  output      logic              vreg_enable,         // regulator output on
  output      logic              vreg_switch,         // current-limited switch mode
  output      logic              vreg_discharge,      // pull output down
  output      logic              vreg_regulate,       // voltage code is in force
  output      r4cs_pkg::r4cs_code_t vreg_code,        // applied voltage code
  output      r4cs_pkg::r4cs_mv_t   vreg_mv,          // decoded target in millivolts
  output      logic              vreg_hibernate,      // hibernate request in force
  output      logic              fault_irq,           // pulse per fault
  output      logic              system_shutdown_req  // pulse asking for system shutdown
);
  import r4cs_pkg::*;

  r4cs_state_t q;
  r4cs_state_t d;
  r4cs_vdec_if vif ();

  r4cs_vdecode u_vdecode (
    .clock   (clock),
    .sys_rst (sys_rst),
    .vif     (vif)
  );

  // ========================================================================
  // Bus decode
  function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] idx);
    reg_hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  logic        hib_req;
  logic        flt_now;
  logic        flt_rise;
  logic        en_next;
  logic        out_on;
  logic [15:0] rword;

  // ========================================================================
  // Next state
  always_comb begin
    d        = q;
    hib_req  = 1'b0;
    flt_now  = q.flt;
    flt_rise = 1'b0;
    en_next  = q.en;
    out_on   = 1'b0;
    rword    = 16'h0000;

    // One wait cycle: read data is captured while waitrequest is high.
    d.ack = (avs_read | avs_write) & ~q.ack;
    if (reg_hit(avs_address, `R4CS_IDX_CTRL)) begin
      rword = {1'b0, q.swi, 3'h0, q.opflt, 5'h00, q.vsel};
    end else if (reg_hit(avs_address, `R4CS_IDX_SEQ)) begin
      rword = {q.act, q.ens, q.sds, 6'h00};
    end else if (reg_hit(avs_address, `R4CS_IDX_LP)) begin
      rword = {2'h0, q.hmode, 2'h0, q.hsrc, 3'h0, q.vimg};
    end else if (reg_hit(avs_address, `R4CS_IDX_STAT)) begin
      rword = {8'h00, q.flt, q.o_hib, q.o_dis, q.o_en, 3'h0, q.hib_bit};
    end
    if (avs_read & ~q.ack) begin
      d.rdata = {16'h0000, rword};
    end
    if (avs_write & q.ack) begin
      if (reg_hit(avs_address, `R4CS_IDX_CTRL)) begin
        d.swi   = avs_writedata[`R4CS_SWI_BIT];
        d.opflt = avs_writedata[`R4CS_OPFLT_BIT];
        d.vsel  = avs_writedata[`R4CS_VSEL_LSB +: 5];
      end
      if (reg_hit(avs_address, `R4CS_IDX_SEQ)) begin
        d.act = avs_writedata[`R4CS_ACT_LSB +: 2];
        d.ens = avs_writedata[`R4CS_ENS_LSB +: 4];
        d.sds = avs_writedata[`R4CS_SDS_LSB +: 4];
      end
      if (reg_hit(avs_address, `R4CS_IDX_LP)) begin
        d.hmode = avs_writedata[`R4CS_HMODE_LSB +: 2];
        d.hsrc  = avs_writedata[`R4CS_HSRC_LSB +: 2];
        d.vimg  = avs_writedata[`R4CS_VIMG_LSB +: 5];
      end
      if (reg_hit(avs_address, `R4CS_IDX_STAT)) begin
        d.hib_bit = avs_writedata[`R4CS_HIB_BIT];
      end
    end

    // Pin inputs settle only when the second and third stages agree.
    d.fsync = {q.fsync[1:0], fault_pin};
    if (q.fsync[1] == q.fsync[2]) begin
      flt_now = q.fsync[2];
    end
    d.flt    = flt_now;
    flt_rise = flt_now & ~q.flt;
    for (int k = 0; k < 3; k++) begin
      d.lsync[k] = {q.lsync[k][1:0], low_power_in[k]};
      if (q.lsync[k][1] == q.lsync[k][2]) begin
        d.lp[k] = q.lsync[k][2];
      end
    end

    case (q.hsrc)
      2'h0:    hib_req = q.hib_bit;
      2'h1:    hib_req = q.lp[0];
      2'h2:    hib_req = q.lp[1];
      2'h3:    hib_req = q.lp[2];
      default: hib_req = 1'b0;
    endcase

    if (slot_strobe && seq_powering_up && q.ens == slot_index &&
        q.ens != `R4CS_SLOT_NONE && q.ens != `R4CS_SLOT_EDGE) begin
      en_next = 1'b1;
    end
    if (enter_active && q.ens == `R4CS_SLOT_EDGE) begin
      en_next = 1'b1;
    end
    if (slot_strobe && !seq_powering_up && q.sds == slot_index &&
        q.sds != `R4CS_SLOT_NONE && q.sds != `R4CS_SLOT_EDGE) begin
      en_next = 1'b0;
    end
    if (enter_off && (q.sds == `R4CS_SLOT_NONE || q.sds == `R4CS_SLOT_EDGE)) begin
      en_next = 1'b0;
    end
    if (flt_rise && q.act == `R4CS_ACT_REG) begin
      en_next = 1'b0;
    end
    d.en = en_next;
    d.irq = flt_rise;
    d.sysdn = flt_rise && q.act[1];

    out_on  = q.en & ~(hib_req && q.hmode == `R4CS_HMODE_OFF);
    d.o_en  = out_on;
    d.o_hib = hib_req;
    d.o_sw  = q.swi;
    // float bit, all off forces discharge
    d.o_dis = ~out_on & (~q.opflt | (&other_regs_off));
    // code only in regulating mode, image code in hibernate when hmode is IMAGE
    if (q.swi) begin
      d.o_code = 5'h00;
    end else if (hib_req && q.hmode == `R4CS_HMODE_IMAGE) begin
      d.o_code = q.vimg;
    end else begin
      d.o_code = q.vsel;
    end
  end

  // ========================================================================
  // State register
  // reset defaults
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q         <= '0;
      q.swi     <= `R4CS_SWI_RST;
      q.opflt   <= `R4CS_OPFLT_RST;
      q.vsel    <= VSEL_DEFAULT;
      q.act     <= `R4CS_ACT_RST;
      q.ens     <= ENS_DEFAULT;
      q.sds     <= `R4CS_SDS_RST;
      q.hmode   <= `R4CS_HMODE_RST;
      q.hsrc    <= `R4CS_HSRC_RST;
      q.vimg    <= `R4CS_VIMG_RST;
      q.o_dis   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign vif.code            = q.o_code;
  assign avs_readdata        = q.rdata;
  assign avs_waitrequest     = (avs_read | avs_write) & ~q.ack;
  assign vreg_enable         = q.o_en;
  assign vreg_switch         = q.o_sw;
  assign vreg_regulate       = ~q.o_sw;
  assign vreg_discharge      = q.o_dis;
  assign vreg_code           = q.o_code;
  assign vreg_mv             = vif.mv;
  assign vreg_hibernate      = q.o_hib;
  assign fault_irq           = q.irq;
  assign system_shutdown_req = q.sysdn;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  switch_mode_a: assert property (q.swi |=> (vreg_switch && vreg_code == 5'h00))
    else $error("switch mode not applied");
  float_dis_a: assert property ((!out_on && !q.opflt) |=> vreg_discharge)
    else $error("disabled output not discharged");
  all_off_dis_a: assert property ((!out_on && (&other_regs_off)) |=> vreg_discharge)
    else $error("all-off discharge missing");
  code_sel_a: assert property ((!q.swi && !hib_req) |=> vreg_code == $past(q.vsel))
    else $error("voltage code not applied");
  fault_off_a: assert property ((flt_rise && q.act == 2'h1) |=> ##1 !vreg_enable)
    else $error("regulator not shut down on fault");
  fault_irq_a: assert property (flt_rise |=> (fault_irq && (system_shutdown_req == $past(q.act[1]))))
    else $error("fault interrupt missing");
  start_active_a: assert property ((enter_active && q.ens == 4'hf && !flt_rise) |=> q.en)
    else $error("start on ACTIVE missing");
  stop_off_a: assert property ((enter_off && q.sds == 4'h0) |=> !q.en)
    else $error("stop on OFF missing");
  hib_off_a: assert property ((hib_req && q.hmode == 2'h1) |=> !vreg_enable)
    else $error("hibernate disable ignored");
  hib_src_a: assert property ((q.hsrc == 2'h2) |=> vreg_hibernate == $past(q.lp[1]))
    else $error("hibernate source wrong");
  image_code_a: assert property ((!q.swi && hib_req && q.hmode == 2'h0) |=> vreg_code == $past(q.vimg))
    else $error("image code not applied");
  reset_dflt_a: assert property ($fell(sys_rst) |-> (q.vimg == 5'h1c && !q.swi && q.act == 2'h0))
    else $error("reset defaults wrong");
  slot_start_a: assert property ((slot_strobe && seq_powering_up && q.ens == slot_index && q.ens != 4'h0 && q.ens != 4'hf && !flt_rise) |=> q.en)
    else $error("slot start missed");

  slot_start_c: cover property (slot_strobe && seq_powering_up && q.ens == slot_index ##1 q.en);
  fault_sys_c:  cover property (flt_rise && q.act[1] ##1 system_shutdown_req);
  hib_image_c:  cover property (hib_req && q.hmode == 2'h0 && q.en);
  bus_write_c:  cover property (avs_write && !avs_waitrequest);
endmodule

// ===== dv/tb_regulator4_control_sequencing.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end

module tb_regulator4_control_sequencing;
  import r4cs_pkg::*;

  logic        clock;
  logic        sys_rst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        slot_strobe;
  logic [3:0]  slot_index;
  logic        seq_powering_up;
  logic        enter_active;
  logic        enter_off;
  logic        fault_pin;
  logic [2:0]  low_power_in;
  logic [2:0]  other_regs_off;
  logic        vreg_enable;
  logic        vreg_switch;
  logic        vreg_discharge;
  logic        vreg_regulate;
  r4cs_code_t  vreg_code;
  r4cs_mv_t    vreg_mv;
  logic        vreg_hibernate;
  logic        fault_irq;
  logic        system_shutdown_req;
  int          fails;
  int          tests_run;
  logic [15:0] rv;
  int          ni;
  int          ns;
  logic [4:0]  codes [5] = '{5'h1b, 5'h00, 5'h0f, 5'h10, 5'h1f};
  logic [11:0] mvs   [5] = '{12'd2900, 12'd900, 12'd1650, 12'd1800, 12'd3300};

  r4cs_regulator dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slot_strobe(slot_strobe), .slot_index(slot_index),
    .seq_powering_up(seq_powering_up), .enter_active(enter_active), .enter_off(enter_off),
    .fault_pin(fault_pin), .low_power_in(low_power_in), .other_regs_off(other_regs_off),
    .vreg_enable(vreg_enable), .vreg_switch(vreg_switch), .vreg_discharge(vreg_discharge),
    .vreg_regulate(vreg_regulate), .vreg_code(vreg_code), .vreg_mv(vreg_mv),
    .vreg_hibernate(vreg_hibernate), .fault_irq(fault_irq),
    .system_shutdown_req(system_shutdown_req)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Bus and sequencer drivers.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    rv = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Events last one cycle; the enable output settles two edges after the event edge.
  task automatic ev(input logic s, input logic [3:0] i, input logic a, input logic o);
    @(posedge clock);
    slot_strobe  <= s;
    slot_index   <= i;
    enter_active <= a;
    enter_off    <= o;
    @(posedge clock);
    slot_strobe  <= 1'b0;
    enter_active <= 1'b0;
    enter_off    <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  // The fault is held high on purpose so a second pulse would show up.
  task automatic fault_run();
    ni = 0;
    ns = 0;
    @(posedge clock);
    fault_pin <= 1'b1;
    repeat (12) begin
      @(negedge clock);
      ni += (fault_irq === 1'b1);
      ns += (system_shutdown_req === 1'b1);
    end
    @(posedge clock);
    fault_pin <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    fails++;
    end_of_test();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    fails = 0; tests_run = 0;
    sys_rst = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = '0;
    slot_strobe = 1'b0; slot_index = '0; seq_powering_up = 1'b1; enter_active = 1'b0;
    enter_off = 1'b0; fault_pin = 1'b0; low_power_in = '0; other_regs_off = '0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, 10'h344, 0); `CHK(rv, 16'h001b)
    bus(0, 10'h348, 0); `CHK(rv, 16'h0000)
    bus(0, 10'h34c, 0); `CHK(rv, 16'h001c)
    bus(1, 10'h354, 16'hffff);
    bus(0, 10'h354, 0); `CHK(rv, 16'h0000)
    settle();
    `CHK(vreg_discharge, 1'b1)
    for (int k = 0; k < 5; k++) begin
      if (k > 0) bus(1, 10'h344, {11'h000, codes[k]});
      settle();
      `CHK(vreg_code, codes[k])
      `CHK(vreg_mv, mvs[k])
    end
    bus(1, 10'h344, 16'h4005); settle();
    `CHK(vreg_switch, 1'b1)
    `CHK(vreg_regulate, 1'b0)
    `CHK(vreg_code, 5'h00)
    bus(1, 10'h344, 16'h0005); settle();
    `CHK(vreg_regulate, 1'b1)
    `CHK(vreg_code, 5'h05)
    bus(1, 10'h348, 16'h0d40);
    ev(1, 4'h2, 0, 0); `CHK(vreg_enable, 1'b0)
    ev(1, 4'h3, 0, 0); `CHK(vreg_enable, 1'b1)
    `CHK(vreg_discharge, 1'b0)
    @(posedge clock);
    seq_powering_up <= 1'b0;
    ev(1, 4'h3, 0, 0); `CHK(vreg_enable, 1'b1)
    ev(1, 4'h5, 0, 0); `CHK(vreg_enable, 1'b0)
    `CHK(vreg_discharge, 1'b1)
    bus(1, 10'h344, 16'h0405); settle();
    `CHK(vreg_discharge, 1'b0)
    @(posedge clock);
    other_regs_off <= 3'b111; settle();
    `CHK(vreg_discharge, 1'b1)
    @(posedge clock);
    other_regs_off <= 3'b011; settle();
    `CHK(vreg_discharge, 1'b0)
    @(posedge clock);
    seq_powering_up <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      bus(1, 10'h348, k ? 16'h3fc0 : 16'h3c00);
      ev(0, 4'h0, 1, 0); `CHK(vreg_enable, 1'b1)
      ev(0, 4'h0, 0, 1); `CHK(vreg_enable, 1'b0)
    end
    bus(1, 10'h348, 16'h0000);
    ev(1, 4'h0, 1, 0); `CHK(vreg_enable, 1'b0)
    for (int a = 0; a < 4; a++) begin
      bus(1, 10'h348, 16'h3c00 | (16'(a) << 14));
      ev(0, 4'h0, 1, 0);
      fault_run();
      `CHK(ni, 1)
      `CHK(ns, (a >= 2) ? 1 : 0)
      `CHK(vreg_enable, (a == 1) ? 1'b0 : 1'b1)
      ev(0, 4'h0, 0, 1);
    end
    bus(1, 10'h348, 16'h3c00);
    ev(0, 4'h0, 1, 0);
    for (int s = 1; s < 4; s++) begin
      bus(1, 10'h34c, 16'h0007 | (16'(s) << 8));
      @(posedge clock);
      low_power_in <= ~(3'b001 << (s - 1)); settle();
      `CHK(vreg_hibernate, 1'b0)
      `CHK(vreg_code, 5'h05)
      @(posedge clock);
      low_power_in <= 3'b001 << (s - 1); settle();
      `CHK(vreg_hibernate, 1'b1)
      `CHK(vreg_code, 5'h07)
    end
    @(posedge clock);
    low_power_in <= 3'b000;
    bus(1, 10'h34c, 16'h0007);
    bus(1, 10'h350, 16'h0001); settle();
    `CHK(vreg_hibernate, 1'b1)
    `CHK(vreg_code, 5'h07)
    `CHK(vreg_enable, 1'b1)
    bus(1, 10'h34c, 16'h1007); settle();
    `CHK(vreg_enable, 1'b0)
    bus(1, 10'h350, 16'h0000);
    bus(0, 10'h34c, 0); `CHK(rv, 16'h1007)
    end_of_test();
  end
endmodule
